// >>> design/hmr_pkg.sv
// shared constants for the hub interrupt mask and phy tuning register slice
package hmr_pkg;
    // register offsets on the configuration port
    localparam logic [7:0] OFS_INT_STATUS = 8'he8;
    localparam logic [7:0] OFS_INT_MASK   = 8'he9;
    localparam logic [7:0] OFS_PORTABLE_HUB_CONFIG       = 8'hee;
    localparam logic [7:0] OFS_SQ3        = 8'hf4;
    localparam logic [7:0] OFS_SQ21       = 8'hf5;
    localparam logic [7:0] OFS_BST3       = 8'hf6;
    // status and mask field positions
    localparam int SUMMARY_BIT = 7;
    localparam int SUSP_BIT    = 4;
    localparam int CFG_BIT     = 3;
    localparam int PWR_BIT     = 2;
    localparam int EVT_LSB     = 2;
    localparam int EVT_N       = 3;
    // portable hub config fields
    localparam int KEEP_CLK_BIT   = 7;
    localparam int LEVEL_MODE_BIT = 6;
    localparam int TOUT_LSB       = 4;
    localparam logic [1:0] CFG_TOUT_CODE = 2'h0;
    localparam int CFG_TOUT_MS    = 95;
    // tuning field positions
    localparam int SQ_W    = 3;
    localparam int SQ1_LSB = 0;
    localparam int SQ2_LSB = 4;
    localparam int SQ3_LSB = 0;
    localparam int BST_LSB = 0;
    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PORTABLE_HUB_CONFIG_RST = 8'h00;
    localparam logic [7:0] SQ_RST   = 8'h00;
    localparam logic [7:0] BST3_RST = 8'h30;
    // writable bits; the rest keep their reset value
    localparam logic [7:0] MASK_WR = 8'h1c;
    localparam logic [7:0] PORTABLE_HUB_CONFIG_WR = 8'hc0;
    localparam logic [7:0] SQ3_WR  = 8'h07;
    localparam logic [7:0] SQ21_WR = 8'h77;
    localparam logic [7:0] BST3_WR = 8'h07;
    // squelch threshold in percent of nominal, indexed by code
    localparam logic [7:0] SQ_PCT [8] = '{8'h64, 8'h5a, 8'h50, 8'h46,
                                          8'h3c, 8'h32, 8'h78, 8'h6e};
    // drive boost in signed percent, indexed by code
    localparam logic signed [7:0] BST_PCT [8] = '{8'sh00, -8'sh05, 8'sh0a, 8'sh05,
                                                  8'sh14, 8'sh0f, 8'sh19, 8'sh00};
endpackage : hmr_pkg

// >>> design/hmr_evt_if.sv
// event, mask and clear signals between the register top and the flag keeper
`timescale 1ns/100ps
interface hmr_evt_if;
    logic [hmr_pkg::EVT_N-1:0] evt;      // one-cycle event pulses
    logic [hmr_pkg::EVT_N-1:0] mask;     // event enables
    logic                      clr_wr;   // write to the status register
    logic [7:0]                clr_data; // zeros clear
    logic [7:0]                status;   // status register image
    modport regs  (output evt, output mask, output clr_wr, output clr_data,
                   input status);
    modport flags (input evt, input mask, input clr_wr, input clr_data,
                   output status);
endinterface : hmr_evt_if

// >>> design/hmr_event_flags.sv
// sticky event flags and the interrupt summary bit
`timescale 1ns/100ps
module hmr_event_flags (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // events, mask and clears
    hmr_evt_if.flags  ev
);
    localparam int N = hmr_pkg::EVT_N;
    localparam int L = hmr_pkg::EVT_LSB;

    logic [N-1:0] flags_q;
    logic [N-1:0] flags_d;
    logic         summary_q;
    logic         summary_d;
    logic [N-1:0] clr_bits;
    logic         clr_sum;
    logic         hit;

    // a zero written clears, a one leaves the bit alone
    assign clr_bits  = ev.clr_wr ? ~ev.clr_data[L+N-1:L] : '0;
    assign clr_sum   = ev.clr_wr & ~ev.clr_data[hmr_pkg::SUMMARY_BIT];
    assign hit       = |(ev.evt & ev.mask);
    // a new event in the clearing cycle survives: set wins
    assign flags_d   = (flags_q & ~clr_bits) | ev.evt;
    assign summary_d = (summary_q & ~clr_sum) | hit;
    assign ev.status = {summary_q, 2'b00, flags_q, 2'b00};

    // flags and summary register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q   <= '0;
            summary_q <= 1'b0;
        end else begin
            flags_q   <= flags_d;
            summary_q <= summary_d;
        end
    end
endmodule : hmr_event_flags

// >>> design/hmr_phy_tune.sv
// decodes squelch and boost codes into percent settings for the phys
`timescale 1ns/100ps
module hmr_phy_tune #(
    parameter int PORTS = 3
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    // codes, port 1 in the low slice
    input  wire logic [PORTS*3-1:0]        sq_code,
    input  wire logic [2:0]                bst3_code,
    // decoded settings
    output logic      [PORTS*8-1:0]        sq_pct,
    output logic signed [7:0]              bst3_pct
);
    // one decoder per downstream port
    for (genvar p = 0; p < PORTS; p++) begin : g_sq
        logic [7:0] pct_q;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) pct_q <= hmr_pkg::SQ_PCT[0];
            else         pct_q <= hmr_pkg::SQ_PCT[sq_code[p*3 +: 3]];
        end
        assign sq_pct[p*8 +: 8] = pct_q;
    end

    // boost decode; upper codes follow the first printed meaning
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) bst3_pct <= hmr_pkg::BST_PCT[0];
        else         bst3_pct <= hmr_pkg::BST_PCT[bst3_code];
    end
endmodule : hmr_phy_tune

// >>> design/hmr_regs.sv
// interrupt mask, portable hub config and phy tuning register slice
`timescale 1ns/100ps
// Functional notes
// - mask bit 4 set lets hub suspend entry pull the interrupt pin low.
// - mask bit 3 set lets host configuration pull the interrupt pin low.
// - mask bit 2 set lets port power updates pull the interrupt pin low.
// - mask and portable config registers reset to zero; no interrupt after reset.
// - config bit 7 keeps clocks running in suspend; clear allows gating.
// - config bit 6 makes the pin a level suspend indication.
// - config bits 5:4 are read only and report code 00, 95 ms.
// - port 3 squelch field bits 2:0 selects threshold in eight steps.
// - port 2 squelch uses bits 6:4 with the same encoding, 110 is 120%.
// - port 1 squelch uses bits 2:0 of the shared register.
// - port 3 boost field scales transmit current; upper codes ambiguous.
// - writing zero to the summary bit releases the pin; ones do nothing.
// - suspend entry sets a sticky flag held until software clears it.
module hmr_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // configuration port register access
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // hub core state and events
    input  wire logic        hub_suspended,
    input  wire logic        host_configured,
    input  wire logic        port_power_updated,
    // interrupt pin and clock control
    output logic             irq_n,
    output logic             clk_gate_en,
    // phy tuning settings
    output logic      [7:0]  port1_squelch_pct,
    output logic      [7:0]  port2_squelch_pct,
    output logic      [7:0]  port3_squelch_pct,
    output logic signed [7:0] port3_boost_pct
);
    // one clock drives everything here
    // the port engine, suspend level and
    // event pulses share that clock, so
    // no input needs a synchroniser
    // gated clocks freeze this block, so
    // suspend is seen before gating
    // every output leaves a flip-flop:
    // pin, gate request, read data and
    // phy settings never glitch while
    // an access is decoded
    // reset puts the pin high and the
    // gate off; the first access may
    // come at the first edge after
    // release
    ////////////////////////////////////////////////////////////////////////
    // storage
    // full byte images; reserved bits
    // keep their reset value through
    // the next-value logic, not the
    // read mux

    logic [7:0]  interrupt_event_mask_q;
    logic [7:0]  portable_hub_config_q;
    logic [7:0]  squelch_port3_q;
    logic [7:0]  squelch_ports_1_2_q;
    logic [7:0]  drive_boost_port3_q;
    logic [7:0]  rdata_q;
    logic        irq_n_q;
    logic        clk_gate_q;
    logic        susp_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    // an unmapped strobe matches none
    // and is dropped
    // reads use none of these terms,
    // so a read never changes state

    logic        wr_stat;
    logic        wr_mask;
    logic        wr_portable_hub_config;
    logic        wr_sq3;
    logic        wr_sq21;
    logic        wr_bst3;

    // writes are plain strobes from the serial port engine on this clock
    assign wr_stat = reg_wr_en && (reg_addr == hmr_pkg::OFS_INT_STATUS);
    assign wr_mask = reg_wr_en && (reg_addr == hmr_pkg::OFS_INT_MASK);
    assign wr_portable_hub_config = reg_wr_en && (reg_addr == hmr_pkg::OFS_PORTABLE_HUB_CONFIG);
    assign wr_sq3  = reg_wr_en && (reg_addr == hmr_pkg::OFS_SQ3);
    assign wr_sq21 = reg_wr_en && (reg_addr == hmr_pkg::OFS_SQ21);
    assign wr_bst3 = reg_wr_en && (reg_addr == hmr_pkg::OFS_BST3);

    ////////////////////////////////////////////////////////////////////////
    // next values; only writable bits take data, the rest keep reset value
    // writable masks live in the package;
    // ones written to reserved bits are
    // harmless and read back as reset

    logic [7:0]  mask_d;
    logic [7:0]  portable_hub_config_d;
    logic [7:0]  sq3_d;
    logic [7:0]  sq21_d;
    logic [7:0]  bst3_d;

    assign mask_d = (hmr_pkg::MASK_RST & ~hmr_pkg::MASK_WR)
                  | (reg_wdata & hmr_pkg::MASK_WR);
    assign portable_hub_config_d = (hmr_pkg::PORTABLE_HUB_CONFIG_RST & ~hmr_pkg::PORTABLE_HUB_CONFIG_WR)
                  | (reg_wdata & hmr_pkg::PORTABLE_HUB_CONFIG_WR);
    assign sq3_d  = (hmr_pkg::SQ_RST & ~hmr_pkg::SQ3_WR)
                  | (reg_wdata & hmr_pkg::SQ3_WR);
    assign sq21_d = (hmr_pkg::SQ_RST & ~hmr_pkg::SQ21_WR)
                  | (reg_wdata & hmr_pkg::SQ21_WR);
    // reserved boost bits keep 0x30 so a read always shows the default
    assign bst3_d = (hmr_pkg::BST3_RST & ~hmr_pkg::BST3_WR)
                  | (reg_wdata & hmr_pkg::BST3_WR);

    // mask and portable config registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_event_mask_q <= hmr_pkg::MASK_RST;
            portable_hub_config_q  <= hmr_pkg::PORTABLE_HUB_CONFIG_RST;
        end else begin
            if (wr_mask) interrupt_event_mask_q <= mask_d;
            if (wr_portable_hub_config) portable_hub_config_q  <= portable_hub_config_d;
        end
    end

    // tuning registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            squelch_port3_q     <= hmr_pkg::SQ_RST;
            squelch_ports_1_2_q <= hmr_pkg::SQ_RST;
            drive_boost_port3_q <= hmr_pkg::BST3_RST;
        end else begin
            if (wr_sq3)  squelch_port3_q     <= sq3_d;
            if (wr_sq21) squelch_ports_1_2_q <= sq21_d;
            if (wr_bst3) drive_boost_port3_q <= bst3_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // config fields
    // the power enable is named for the
    // event that it passes to the pin

    logic        suspend_event_enable;
    logic        host_config_event_enable;
    logic        power_event_enable;
    logic        keep_clock_in_suspend;
    logic        irq_pin_suspend_level_mode;
    logic [1:0]  config_window_timeout;

    assign suspend_event_enable     = interrupt_event_mask_q[hmr_pkg::SUSP_BIT];
    assign host_config_event_enable = interrupt_event_mask_q[hmr_pkg::CFG_BIT];
    assign power_event_enable       = interrupt_event_mask_q[hmr_pkg::PWR_BIT];
    assign keep_clock_in_suspend    = portable_hub_config_q[hmr_pkg::KEEP_CLK_BIT];
    assign irq_pin_suspend_level_mode
                                    = portable_hub_config_q[hmr_pkg::LEVEL_MODE_BIT];
    // fixed code: the slice has no other timeout option to offer
    assign config_window_timeout    = hmr_pkg::CFG_TOUT_CODE;

    ////////////////////////////////////////////////////////////////////////
    // events
    // core events come as one-cycle
    // pulses; suspend comes as a level
    // the edge detector resets low, the
    // idle level, so a hub suspended out
    // of reset is reported as an entry
    // at the first edge after release

    logic        suspend_entry;

    // suspend entry is the rising edge of the core's suspend level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) susp_prev_q <= 1'b0;
        else         susp_prev_q <= hub_suspended;
    end
    assign suspend_entry = hub_suspended & ~susp_prev_q;

    hmr_evt_if ev ();

    assign ev.evt      = {suspend_entry, host_configured, port_power_updated};
    assign ev.mask     = {suspend_event_enable,
                          host_config_event_enable,
                          power_event_enable};
    assign ev.clr_wr   = wr_stat;
    assign ev.clr_data = reg_wdata;

    hmr_event_flags u_flags (
        .clk    (clk),
        .arst_n (arst_n),
        .ev     (ev.flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin and clock gating
    // the pin trails the summary by one
    // edge; a clear meeting a new event
    // leaves it low, as the set wins
    // level mode ignores the summary
    // and follows suspend, one edge late
    // the gate output only requests;
    // the clock block owns the gate

    logic        irq_n_d;
    logic        clk_gate_d;

    // level mode tracks suspend itself, event mode the latched summary
    assign irq_n_d = irq_pin_suspend_level_mode
                   ? ~hub_suspended
                   : ~ev.status[hmr_pkg::SUMMARY_BIT];
    // gating saves suspend current; the serial port is dead while gated
    assign clk_gate_d = hub_suspended & ~keep_clock_in_suspend;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_n_q    <= 1'b1;
            clk_gate_q <= 1'b0;
        end else begin
            irq_n_q    <= irq_n_d;
            clk_gate_q <= clk_gate_d;
        end
    end

    assign irq_n       = irq_n_q;
    assign clk_gate_en = clk_gate_q;

    ////////////////////////////////////////////////////////////////////////
    // read path
    // data is caught on the strobe edge
    // and then left alone, so a slow
    // serial engine may shift it out
    // over many cycles

    logic [7:0]  portable_hub_config_rd;
    logic [7:0]  rd_mux;
    logic        sel_stat;
    logic        sel_mask;
    logic        sel_portable_hub_config;
    logic        sel_sq3;
    logic        sel_sq21;
    logic        sel_bst3;

    assign portable_hub_config_rd = {portable_hub_config_q[7:6], config_window_timeout,
                      portable_hub_config_q[3:0]};

    // one select per mapped offset; exact compare, at most one high
    assign sel_stat = (reg_addr == hmr_pkg::OFS_INT_STATUS);
    assign sel_mask = (reg_addr == hmr_pkg::OFS_INT_MASK);
    assign sel_portable_hub_config = (reg_addr == hmr_pkg::OFS_PORTABLE_HUB_CONFIG);
    assign sel_sq3  = (reg_addr == hmr_pkg::OFS_SQ3);
    assign sel_sq21 = (reg_addr == hmr_pkg::OFS_SQ21);
    assign sel_bst3 = (reg_addr == hmr_pkg::OFS_BST3);

    // and-or selection; unmapped addresses select nothing and read zero
    assign rd_mux = ({8{sel_stat}} & ev.status)
                  | ({8{sel_mask}} & interrupt_event_mask_q)
                  | ({8{sel_portable_hub_config}} & portable_hub_config_rd)
                  | ({8{sel_sq3}}  & squelch_port3_q)
                  | ({8{sel_sq21}} & squelch_ports_1_2_q)
                  | ({8{sel_bst3}} & drive_boost_port3_q);

    // read data is held until the next read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)        rdata_q <= 8'h00;
        else if (reg_rd_en) rdata_q <= rd_mux;
    end
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // phy tuning decode
    // decoded here so the analogue trims
    // see a settled value one edge after
    // the write; port 1 rides in the low
    // slice of the code bus, port 3 in
    // the high slice; upper boost codes
    // are ambiguous, see the decoder

    logic [2:0]  port1_squelch_level;
    logic [2:0]  port2_squelch_level;
    logic [2:0]  port3_squelch_level;
    logic [23:0] sq_pct;

    assign port1_squelch_level = squelch_ports_1_2_q[hmr_pkg::SQ1_LSB +: 3];
    assign port2_squelch_level = squelch_ports_1_2_q[hmr_pkg::SQ2_LSB +: 3];
    assign port3_squelch_level = squelch_port3_q[hmr_pkg::SQ3_LSB +: 3];

    hmr_phy_tune #(
        .PORTS (3)
    ) u_tune (
        .clk       (clk),
        .arst_n    (arst_n),
        .sq_code   ({port3_squelch_level, port2_squelch_level,
                     port1_squelch_level}),
        .bst3_code (drive_boost_port3_q[hmr_pkg::BST_LSB +: 3]),
        .sq_pct    (sq_pct),
        .bst3_pct  (port3_boost_pct)
    );

    assign port1_squelch_pct = sq_pct[7:0];
    assign port2_squelch_pct = sq_pct[15:8];
    assign port3_squelch_pct = sq_pct[23:16];
endmodule : hmr_regs

// >>> dv/hmr_regs_props.sv
// checker of pin, clock gate and readback timing for the register slice
`timescale 1ns/100ps
module hmr_regs_props (
    // clock and reset
    input logic       clk,
    input logic       arst_n,
    // register port
    input logic [7:0] reg_addr,
    input logic       reg_wr_en,
    input logic       reg_rd_en,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    // hub core, pin and gate
    input logic       hub_suspended,
    input logic       host_configured,
    input logic       port_power_updated,
    input logic       irq_n,
    input logic       clk_gate_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    // shadows rebuilt from port writes, so no internal probe is needed
    logic [7:0] mask_q;
    logic [7:0] cfg_q;
    logic       clr_wr;
    logic       rd_bad;
    assign clr_wr = reg_wr_en && reg_addr == 8'he8 && !reg_wdata[7];
    assign rd_bad = reg_rd_en && !(reg_addr inside {8'he8, 8'he9, 8'hee, 8'hf4, 8'hf5, 8'hf6});
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) mask_q <= 8'h00;
        else if (reg_wr_en && reg_addr == 8'he9) mask_q <= reg_wdata;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) cfg_q <= 8'h00;
        else if (reg_wr_en && reg_addr == 8'hee) cfg_q <= reg_wdata;
    end
    ////////////////////////////////////////////////////////////
    // event paths to the pin, two edges from cause to pin
    property p_susp; $rose(hub_suspended) && mask_q[4] && !cfg_q[6] |-> ##2 !irq_n; endproperty
    a_susp: assert property (p_susp) else $error("suspend entry missed pin");
    property p_cfg; host_configured && mask_q[3] && !cfg_q[6] |-> ##2 !irq_n; endproperty
    a_cfg: assert property (p_cfg) else $error("host config missed pin");
    property p_pwr; port_power_updated && mask_q[2] && !cfg_q[6] |-> ##2 !irq_n; endproperty
    a_pwr: assert property (p_pwr) else $error("power update missed pin");
    property p_clr;
        clr_wr && !cfg_q[6] && !host_configured && !port_power_updated && !$rose(hub_suspended)
        |-> ##2 irq_n;
    endproperty
    a_clr: assert property (p_clr) else $error("summary clear did not release pin");
    property p_gate; clk_gate_en == ($past(hub_suspended) && !$past(cfg_q[7])); endproperty
    a_gate: assert property (p_gate) else $error("clock gate wrong");
    property p_lvl; cfg_q[6] && $past(cfg_q[6]) |-> irq_n == !$past(hub_suspended); endproperty
    a_lvl: assert property (p_lvl) else $error("level mode pin wrong");
    property p_tout; reg_rd_en && reg_addr == 8'hee |=> reg_rdata[5:0] == 6'h00; endproperty
    a_tout: assert property (p_tout) else $error("config read-only field wrong");
    property p_unmap; rd_bad |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rst; $rose(arst_n) |-> irq_n && !clk_gate_en; endproperty
    a_rst: assert property (p_rst) else $error("pin or gate active after reset");
    c_cfg: cover property (host_configured && mask_q[3]);
    c_clr: cover property (clr_wr);
    c_lvl: cover property (cfg_q[6] && hub_suspended);
endmodule : hmr_regs_props
bind hmr_regs hmr_regs_props u_props (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hub_suspended(hub_suspended), .host_configured(host_configured),
    .port_power_updated(port_power_updated), .irq_n(irq_n), .clk_gate_en(clk_gate_en));

// >>> dv/hmr_host_model.sv
// system host model driving byte accesses on the configuration port
`timescale 1ns/100ps
module hmr_host_model (
    // clock
    input  logic       clk,
    // register port
    output logic [7:0] reg_addr,
    output logic       reg_wr_en,
    output logic       reg_rd_en,
    output logic [7:0] reg_wdata,
    input  logic [7:0] reg_rdata
);
    ////////////////////////////////////////////////////////////
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end
    // one strobe per access; stale lines are inverted so nothing leans on them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    // read data is registered, so it is taken after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : hmr_host_model

// >>> dv/hmr_regs_tb_top.sv
// self-checking bench for the register slice
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module hmr_regs_tb_top;
    typedef struct packed { logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e; } hmr_row_t;
    localparam hmr_row_t ROWS [16] = '{
        '{1'h0, 8'he8, 8'h00, 8'h00}, '{1'h0, 8'he9, 8'h00, 8'h00}, '{1'h0, 8'hee, 8'h00, 8'h00},
        '{1'h0, 8'hf4, 8'h00, 8'h00}, '{1'h0, 8'hf5, 8'h00, 8'h00}, '{1'h0, 8'hf6, 8'h00, 8'h30},
        '{1'h1, 8'he9, 8'hff, 8'h1c}, '{1'h1, 8'hee, 8'h3f, 8'h00}, '{1'h1, 8'hf4, 8'hff, 8'h07},
        '{1'h1, 8'hf5, 8'hff, 8'h77}, '{1'h1, 8'hf6, 8'hff, 8'h37}, '{1'h1, 8'ha5, 8'hff, 8'h00},
        '{1'h1, 8'he9, 8'h00, 8'h00}, '{1'h1, 8'hf4, 8'h00, 8'h00}, '{1'h1, 8'hf5, 8'h00, 8'h00},
        '{1'h1, 8'hf6, 8'h00, 8'h30}};
    localparam logic [7:0] SQ_EXP [8] = '{8'h64, 8'h5a, 8'h50, 8'h46, 8'h3c, 8'h32, 8'h78, 8'h6e};
    localparam logic [7:0] BST_EXP [8] = '{8'h00, 8'hfb, 8'h0a, 8'h05, 8'h14, 8'h0f, 8'h19, 8'h00};
    localparam logic [7:0] EV_BIT [3] = '{8'h08, 8'h04, 8'h10};
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              hub_suspended = 1'b0;
    logic              host_configured = 1'b0;
    logic              port_power_updated = 1'b0;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata, rd_v, sq1, sq2, sq3;
    logic              reg_wr_en, reg_rd_en, irq_n, clk_gate_en;
    logic signed [7:0] bst;
    int                n_fail = 0;
    int                total_checks = 0;
    ////////////////////////////////////////////////////////////
    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    hmr_regs dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .hub_suspended(hub_suspended), .host_configured(host_configured),
        .port_power_updated(port_power_updated), .irq_n(irq_n), .clk_gate_en(clk_gate_en),
        .port1_squelch_pct(sq1), .port2_squelch_pct(sq2), .port3_squelch_pct(sq3),
        .port3_boost_pct(bst));
    hmr_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // verdict and run end, shared by the main sequence and the watchdog
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // one-cycle event pulse; suspend is a level left high for the caller to drop
    task automatic fire(input int i);
        if (i == 2) hub_suspended = 1'b1;
        else if (i == 1) port_power_updated = 1'b1;
        else host_configured = 1'b1;
        @(negedge clk);
        host_configured = 1'b0;
        port_power_updated = 1'b0;
    endtask : fire
    ////////////////////////////////////////////////////////////
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        `CHK("irq_n", 1'h1, irq_n)
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) u_host.wr(ROWS[i].a, ROWS[i].d);
            u_host.rd(ROWS[i].a, rd_v);
            `CHK("readback", ROWS[i].e, rd_v)
        end
        // every squelch and boost code, ports 1 and 2 given different codes
        for (int c = 0; c < 8; c++) begin
            u_host.wr(8'hf4, 8'(c));
            u_host.wr(8'hf5, {1'h0, 3'(7 - c), 1'h0, 3'(c)});
            u_host.wr(8'hf6, 8'(c));
            @(negedge clk);
            `CHK("sq3", SQ_EXP[c], sq3)
            `CHK("sq2", SQ_EXP[7 - c], sq2)
            `CHK("sq1", SQ_EXP[c], sq1)
            `CHK("boost", BST_EXP[c], bst)
        end
        // each event masked then unmasked, cleared summary first, flag after
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 3; i++) begin
                u_host.wr(8'he9, m ? EV_BIT[i] : 8'h00);
                @(negedge clk);
                fire(i);
                repeat (2) @(negedge clk);
                `CHK("irq_n", 1'(!m), irq_n)
                u_host.rd(8'he8, rd_v);
                `CHK("status", EV_BIT[i] | (m ? 8'h80 : 8'h00), rd_v)
                if (i == 2) `CHK("clk_gate", 1'h1, clk_gate_en)
                u_host.wr(8'he8, 8'h7f);
                @(negedge clk);
                `CHK("irq_n", 1'h1, irq_n)
                u_host.rd(8'he8, rd_v);
                `CHK("status", EV_BIT[i], rd_v)
                u_host.wr(8'he8, 8'h00);
                hub_suspended = 1'b0;
            end
        end
        // level mode follows suspend; keep-clock bit stops gating
        u_host.wr(8'hee, 8'h40);
        hub_suspended = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("irq_n", 1'h0, irq_n)
        `CHK("clk_gate", 1'h1, clk_gate_en)
        u_host.wr(8'hee, 8'hc0);
        @(negedge clk);
        `CHK("clk_gate", 1'h0, clk_gate_en)
        hub_suspended = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("irq_n", 1'h1, irq_n)
        // reset in mid-run restores defaults
        u_host.wr(8'he9, 8'h1c);
        u_host.wr(8'hf6, 8'h05);
        arst_n = 1'b0;
        @(negedge clk);
        `CHK("boost", 8'h00, bst)
        arst_n = 1'b1;
        u_host.rd(8'he9, rd_v);
        `CHK("mask", 8'h00, rd_v)
        u_host.rd(8'hf6, rd_v);
        `CHK("boost_reg", 8'h30, rd_v)
        give_verdict();
    end
endmodule : hmr_regs_tb_top
